// file: verilog/crc_unit_pkg.sv
// constants for the memory range checksum unit
package crc_unit_pkg;
    // ==========================================================
    // register map (byte offsets)
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_ADDR   = 8'h08;
    localparam logic [7:0] OFS_LENGTH = 8'h0C;
    localparam logic [7:0] OFS_DATA   = 8'h10;
    // ==========================================================
    // field positions
    localparam int CTRL_START    = 0;
    localparam int STAT_BUSY     = 0;
    localparam int STAT_DONE     = 1;
    localparam int STAT_BUS_ERR  = 2;
    localparam int STAT_RANGE    = 3;
    localparam int STAT_ALIGN    = 4;
    localparam int MODE_LSB      = 0;
    localparam int MODE_W        = 2;
    localparam logic [1:0] MODE_MAIN_FLASH = 2'h0;
    localparam logic [1:0] MODE_EEPROM     = 2'h1;
    localparam logic [1:0] WORD_LOW_BITS   = 2'h0;
    // ==========================================================
    // checksum constants
    localparam logic [31:0] CRC_POLY_REFL = 32'hEDB88320;
    localparam logic [31:0] CRC_SEED_ONES = 32'hFFFFFFFF;
    localparam logic [31:0] WORD_BYTES    = 32'h00000004;
    localparam logic [31:0] RESET_WORD    = 32'h00000000;
endpackage

// file: verilog/crc32_word_step.sv
// one 32-bit word folded into a reflected crc32 remainder
`timescale 1ns/1ps
module crc32_word_step
    import crc_unit_pkg::*;
(
    input  wire logic [31:0] crcIn,
    input  wire logic [31:0] word,
    output logic      [31:0] crcOut
);
    // lsb-first bit order makes a little-endian word equal four bytes in address order
    always_comb begin
        logic [31:0] c;
        c = crcIn ^ word;
        for (int i = 0; i < 32; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
        end
        crcOut = c;
    end
endmodule

// file: verilog/mem_word_reader.sv
// single-word read master with request held until acknowledged
`timescale 1ns/1ps
module mem_word_reader (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        go,
    input  wire logic [31:0] addr,
    output logic             memReq,
    output logic      [31:0] memAddr,
    input  wire logic        memAck,
    input  wire logic [31:0] memRdata,
    input  wire logic        memErr,
    output logic             wordValid,
    output logic      [31:0] wordData,
    output logic             wordErr
);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            memReq  <= 1'b0;
            memAddr <= 32'h00000000;
        end else if (go && !memReq) begin
            memReq  <= 1'b1;
            memAddr <= addr;
        end else if (memAck) begin
            memReq  <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wordValid <= 1'b0;
            wordData  <= 32'h00000000;
            wordErr   <= 1'b0;
        end else begin
            wordValid <= memReq && memAck;
            wordErr   <= memReq && memAck && memErr;
            if (memReq && memAck) begin
                wordData <= memRdata;
            end
        end
    end
endmodule

// file: verilog/memory_range_crc32_unit.sv
// memory range crc32 unit of the device service unit, apb register slave
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module memory_range_crc32_unit
    import crc_unit_pkg::*;
#(
    parameter logic [31:0] NVM_BASE   = 32'h00000000,
    parameter logic [31:0] FLASH_SIZE = 32'h00004000,
    parameter logic [31:0] EE_BASE    = 32'h00004000,
    parameter logic [31:0] EE_SIZE    = 32'h00001000,
    parameter logic [31:0] RAM_BASE   = 32'h20000000,
    parameter logic [31:0] RAM_SIZE   = 32'h00002000
)
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    input  wire logic        extRange,
    output logic             memReq,
    output logic      [31:0] memAddr,
    input  wire logic        memAck,
    input  wire logic [31:0] memRdata,
    input  wire logic        memErr
);
    // ==========================================================
    // types and state
    typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} state_type;

    state_type   state;
    logic [31:0] addrReg;
    logic [31:0] lengthReg;
    logic [31:0] dataReg;
    logic        addrLoaded;
    logic        lenLoaded;
    logic        done;
    logic        busErr;
    logic        rangeErr;
    logic        alignErr;
    logic        extMode;
    logic [31:0] curAddr;
    logic [31:0] remaining;
    logic [31:0] crc;
    logic [31:0] crcNext;
    logic        readGo;
    logic        wordValid;
    logic [31:0] wordData;
    logic        wordErr;

    function automatic logic fits(input logic [31:0] b, input logic [31:0] n,
                                  input logic [31:0] lo, input logic [31:0] sz);
        fits = (b >= lo) && (n <= sz) && ((b - lo) <= (sz - n));
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_ADDR) ||
                 (a == OFS_LENGTH) || (a == OFS_DATA);
    endfunction

    // ==========================================================
    // apb slave: no wait state, pready high in the first access cycle, answer prepared in the setup cycle
    logic setupPh;
    logic accessPh;
    logic wrAcc;
    logic busyWrite;

    assign setupPh   = psel && !penable && !pready;
    assign accessPh  = psel && penable && pready;
    assign wrAcc     = accessPh && pwrite && !pslverr;
    assign busyWrite = (state != ST_IDLE) && (paddr != OFS_CTRL) && (paddr != OFS_STATUS);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setupPh;
            // writes to the setup registers during a run would corrupt the checksum
            pslverr <= setupPh && (!mapped(paddr) || (pwrite && busyWrite));
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prdata <= RESET_WORD;
        end else if (setupPh && !pwrite) begin
            unique case (paddr)
                OFS_STATUS: begin
                    prdata <= RESET_WORD;
                    prdata[STAT_BUSY]    <= state != ST_IDLE;
                    prdata[STAT_DONE]    <= done;
                    prdata[STAT_BUS_ERR] <= busErr;
                    prdata[STAT_RANGE]   <= rangeErr;
                    prdata[STAT_ALIGN]   <= alignErr;
                end
                OFS_ADDR:   prdata <= addrReg;
                OFS_LENGTH: prdata <= lengthReg;
                OFS_DATA:   prdata <= dataReg;
                default:    prdata <= RESET_WORD;
            endcase
        end
    end

    // ==========================================================
    // start decode and region selection
    logic        startReq;
    logic        accept;
    logic        refuse;
    logic [31:0] next_base;
    logic [31:0] next_len;
    logic [31:0] next_seed;
    logic        next_rangeBad;
    logic        next_alignBad;
    logic [1:0]  modeSel;

    assign startReq = wrAcc && (paddr == OFS_CTRL) && pwdata[CTRL_START] && (state == ST_IDLE);
    assign modeSel  = addrReg[MODE_LSB +: MODE_W];

    always_comb begin
        next_base     = {addrReg[31:MODE_W], WORD_LOW_BITS};
        next_len      = lengthReg;
        next_seed     = dataReg;
        next_alignBad = 1'b0;
        next_rangeBad = 1'b0;
        if (extRange) begin
            next_seed = CRC_SEED_ONES;
            if (modeSel == MODE_MAIN_FLASH) begin
                next_base = NVM_BASE;
                next_len  = FLASH_SIZE;
            end else if (modeSel == MODE_EEPROM) begin
                next_base = EE_BASE;
                next_len  = EE_SIZE;
            end else begin
                next_rangeBad = 1'b1;
            end
        end else begin
            next_alignBad = lengthReg[MODE_W-1:0] != WORD_LOW_BITS;
            // nvm covers main flash plus the eeprom emulation area
            next_rangeBad = !(addrLoaded && lenLoaded) ||
                            !(fits(next_base, lengthReg, NVM_BASE, FLASH_SIZE + EE_SIZE) ||
                              fits(next_base, lengthReg, RAM_BASE, RAM_SIZE));
        end
    end

    assign refuse = startReq && (next_rangeBad || next_alignBad);
    assign accept = startReq && !refuse;

    // ==========================================================
    // software configuration registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            addrReg    <= RESET_WORD;
            addrLoaded <= 1'b0;
        end else if (wrAcc && paddr == OFS_ADDR) begin
            addrReg    <= pwdata;
            addrLoaded <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lengthReg <= RESET_WORD;
            lenLoaded <= 1'b0;
        end else if (wrAcc && paddr == OFS_LENGTH) begin
            lengthReg <= pwdata;
            lenLoaded <= 1'b1;
        end
    end

    // forced seeds in external modes also land in data, as a read before the end shows
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dataReg <= RESET_WORD;
        end else if (accept && extRange) begin
            dataReg <= CRC_SEED_ONES;
        end else if (state == ST_ISSUE && remaining == RESET_WORD) begin
            dataReg <= ~crc;
        end else if (wrAcc && paddr == OFS_DATA) begin
            dataReg <= pwdata;
        end
    end

    // ==========================================================
    // sequencer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state     <= ST_IDLE;
            curAddr   <= RESET_WORD;
            remaining <= RESET_WORD;
            crc       <= RESET_WORD;
            extMode   <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (accept) begin
                        state     <= ST_ISSUE;
                        curAddr   <= next_base;
                        remaining <= next_len;
                        crc       <= next_seed;
                        extMode   <= extRange;
                    end
                end
                ST_ISSUE: begin
                    state <= (remaining == RESET_WORD) ? ST_IDLE : ST_WAIT;
                end
                ST_WAIT: begin
                    if (wordValid) begin
                        state     <= wordErr ? ST_IDLE : ST_ISSUE;
                        curAddr   <= curAddr + WORD_BYTES;
                        remaining <= remaining - WORD_BYTES;
                        crc       <= crcNext;
                    end
                end
            endcase
        end
    end

    assign readGo = (state == ST_ISSUE) && (remaining != RESET_WORD);

    // status flags: an accepted start clears them, a refused start sets done with its error flag, a run can only end while nothing restarts it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            done     <= 1'b0;
            busErr   <= 1'b0;
            rangeErr <= 1'b0;
            alignErr <= 1'b0;
        end else if (startReq) begin
            done     <= refuse;
            busErr   <= 1'b0;
            rangeErr <= next_rangeBad;
            alignErr <= next_alignBad;
        end else if ((state == ST_ISSUE && remaining == RESET_WORD) ||
                     (state == ST_WAIT && wordValid && wordErr)) begin
            done   <= 1'b1;
            busErr <= wordErr;
        end
    end

    // ==========================================================
    // datapath submodules
    crc32_word_step u_step (
        .crcIn  (crc),
        .word   (wordData),
        .crcOut (crcNext)
    );

    mem_word_reader u_reader (
        .clock     (clock),
        .rst_n     (rst_n),
        .go        (readGo),
        .addr      (curAddr),
        .memReq    (memReq),
        .memAddr   (memAddr),
        .memAck    (memAck),
        .memRdata  (memRdata),
        .memErr    (memErr),
        .wordValid (wordValid),
        .wordData  (wordData),
        .wordErr   (wordErr)
    );

    // ==========================================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    noLoadStart_a: assert property (startReq && !extRange && !(addrLoaded && lenLoaded)
        |=> state == ST_IDLE && rangeErr && done) else $error("start without loaded region");
    alignRefuse_a: assert property (startReq && !extRange && lengthReg[MODE_W-1:0] != WORD_LOW_BITS
        |=> state == ST_IDLE && alignErr) else $error("unaligned length accepted");
    seedTaken_a: assert property (accept && !extRange
        |=> crc == $past(dataReg)) else $error("seed not taken from data");
    finalData_a: assert property (state == ST_ISSUE && remaining == RESET_WORD
        |=> dataReg == ~$past(crc) && done && state == ST_IDLE) else $error("result not stored");
    intRange_a: assert property (accept && !extRange |=> fits(curAddr, remaining, NVM_BASE, FLASH_SIZE + EE_SIZE) ||
        fits(curAddr, remaining, RAM_BASE, RAM_SIZE)) else $error("bad region");
    extRegion_a: assert property (memReq && extMode |-> fits(memAddr, WORD_BYTES, NVM_BASE, FLASH_SIZE) ||
        fits(memAddr, WORD_BYTES, EE_BASE, EE_SIZE)) else $error("external read outside region");
    extMode_a: assert property (startReq && extRange && modeSel > MODE_EEPROM
        |=> state == ST_IDLE && rangeErr) else $error("illegal mode accepted");
    flashMode_a: assert property (startReq && extRange && modeSel == MODE_MAIN_FLASH
        |=> curAddr == NVM_BASE && remaining == FLASH_SIZE && crc == CRC_SEED_ONES)
        else $error("main flash region wrong");
    eeMode_a: assert property (startReq && extRange && modeSel == MODE_EEPROM
        |=> curAddr == EE_BASE && remaining == EE_SIZE && dataReg == CRC_SEED_ONES)
        else $error("eeprom region wrong");
    readHold_a: assert property (memReq && !memAck
        |=> memReq && $stable(memAddr) && memAddr == curAddr) else $error("read request dropped");
    busyDone_a: assert property (state != ST_IDLE |-> !done) else $error("done while busy");
    apbAnswer_a: assert property (setupPh |=> pready ##1 !pready) else $error("apb answer timing");

    flashRun_c: cover property (accept && extRange && modeSel == MODE_MAIN_FLASH);
    ramRun_c:   cover property (accept && !extRange && next_base >= RAM_BASE ##[1:40] done);
    busErr_c:   cover property (state == ST_WAIT && wordValid && wordErr);
endmodule

// file: tb/mem_model.sv
// behavioural memory behind the checksum unit's read port
`timescale 1ns/1ps
module mem_model (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        memReq,
    input  wire logic [31:0] memAddr,
    input  wire logic [3:0]  stall,
    input  wire logic        errEn,
    input  wire logic [31:0] errAddr,
    output logic             memAck,
    output logic      [31:0] memRdata,
    output logic             memErr
);
    // ==========================================================
    // content: a pattern derived from the address
    function automatic logic [31:0] word(input logic [31:0] a);
        return {a[15:0], ~a[15:0]} ^ 32'h5A3C96E1;
    endfunction

    logic [3:0] waitCount;

    // ==========================================================
    // one read at a time; data toggles while no answer is given so stale values never look valid
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            memAck    <= 1'b0;
            memErr    <= 1'b0;
            memRdata  <= 32'h00000000;
            waitCount <= 4'h0;
        end else begin
            memAck   <= 1'b0;
            memErr   <= 1'b0;
            memRdata <= ~memRdata;
            if (memReq && !memAck) begin
                if (waitCount == stall) begin
                    memAck    <= 1'b1;
                    memRdata  <= word(memAddr);
                    memErr    <= errEn && (memAddr == errAddr);
                    waitCount <= 4'h0;
                end else begin
                    waitCount <= waitCount + 4'h1;
                end
            end
        end
    end
endmodule

// file: tb/tb.sv
// self-checking bench for the memory range checksum unit
`timescale 1ns/1ps
module tb;
    import crc_unit_pkg::*;
    // ==========================================================
    // small regions keep the whole-array modes short
    localparam logic [31:0] FLASH_SZ = 32'h00000040;
    localparam logic [31:0] EE_B     = 32'h00000040;
    localparam logic [31:0] EE_SZ    = 32'h00000020;
    localparam logic [31:0] RAM_B    = 32'h20000000;
    localparam logic [31:0] RAM_SZ   = 32'h00000100;

    logic        clock    = 1'b0;
    logic        rst_n    = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h00000000;
    logic        extRange = 1'b0;
    logic        errEn    = 1'b0;
    logic [31:0] errAddr  = 32'h00000000;
    logic [3:0]  stall    = 4'h0;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        memReq;
    logic [31:0] memAddr;
    logic        memAck;
    logic [31:0] memRdata;
    logic        memErr;
    logic [31:0] rd;
    logic        er;
    int          failures = 0;
    int          samples_checked = 0;

    always #5 clock = ~clock;

    memory_range_crc32_unit #(.NVM_BASE(32'h00000000), .FLASH_SIZE(FLASH_SZ), .EE_BASE(EE_B), .EE_SIZE(EE_SZ),
                              .RAM_BASE(RAM_B), .RAM_SIZE(RAM_SZ)) uut (
        .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .extRange(extRange),
        .memReq(memReq), .memAddr(memAddr), .memAck(memAck), .memRdata(memRdata), .memErr(memErr));

    mem_model partner (
        .clock(clock), .rst_n(rst_n), .memReq(memReq), .memAddr(memAddr), .stall(stall), .errEn(errEn),
        .errAddr(errAddr), .memAck(memAck), .memRdata(memRdata), .memErr(memErr));

    // ==========================================================
    // reference checksum, reflected, little-endian bytes
    function automatic logic [31:0] crcOf(input logic [31:0] seed, input logic [31:0] base, input logic [31:0] len);
        logic [31:0] c;
        logic [31:0] w;
        c = seed;
        for (logic [31:0] a = base; a < base + len; a += 32'h4) begin
            w = {a[15:0], ~a[15:0]} ^ 32'h5A3C96E1;
            for (int i = 0; i < 32; i++) begin
                c = (c[0] ^ w[i]) ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
            end
        end
        return ~c;
    endfunction

    // ==========================================================
    // bus access and comparison
    // waits as long as the slave needs; only the watchdog ends a hung transfer
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chkFlag(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic run(input logic [31:0] a, input logic [31:0] len, input logic [31:0] seed);
        apb(1'b1, OFS_ADDR, a);
        apb(1'b1, OFS_LENGTH, len);
        apb(1'b1, OFS_DATA, seed);
        apb(1'b1, OFS_CTRL, 32'h00000001);
    endtask

    // polls status until done or 500 reads, then compares the whole status word
    task automatic waitStatus(input logic [31:0] exp);
        int n;
        n = 0;
        do begin
            apb(1'b0, OFS_STATUS, 32'h00000000);
            n++;
        end while (rd[STAT_DONE] !== 1'b1 && n < 500);
        chk("status", exp, rd);
    endtask

    task automatic dataIs(input logic [31:0] exp);
        apb(1'b0, OFS_DATA, 32'h00000000);
        chk("data", exp, rd);
    endtask

    task automatic end_of_test;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge clock);
        failures++;
        end_of_test;
    end

    // ==========================================================
    // scenarios
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        apb(1'b0, OFS_STATUS, 32'h00000000);
        chk("status after reset", 32'h00000000, rd);
        dataIs(32'h00000000);
        apb(1'b1, OFS_CTRL, 32'h00000001);
        waitStatus(32'h0000000A);
        run(32'h00000010, 32'h00000008, 32'hFFFFFFFF);
        apb(1'b0, OFS_STATUS, 32'h00000000);
        chk("busy", 32'h00000001, rd);
        apb(1'b1, OFS_LENGTH, 32'h00000004);
        chkFlag("write while busy", 1'b1, er);
        waitStatus(32'h00000002);
        dataIs(crcOf(32'hFFFFFFFF, 32'h00000010, 32'h00000008));
        stall <= 4'h3;
        run(RAM_B + 32'h8, 32'h0000000C, 32'h12345678);
        waitStatus(32'h00000002);
        dataIs(crcOf(32'h12345678, RAM_B + 32'h8, 32'h0000000C));
        run(EE_B + EE_SZ - 32'h4, 32'h00000004, 32'hFFFFFFFF);
        waitStatus(32'h00000002);
        dataIs(crcOf(32'hFFFFFFFF, EE_B + EE_SZ - 32'h4, 32'h00000004));
        run(RAM_B, 32'h00000000, 32'h0F0F0F0F);
        waitStatus(32'h00000002);
        dataIs(32'hF0F0F0F0);
        run(32'h00000000, 32'h00000006, 32'hFFFFFFFF);
        waitStatus(32'h00000012);
        run(RAM_B + RAM_SZ - 32'h4, 32'h00000008, 32'hFFFFFFFF);
        waitStatus(32'h0000000A);
        errEn   <= 1'b1;
        errAddr <= RAM_B + 32'h4;
        run(RAM_B, 32'h0000000C, 32'h55AA55AA);
        waitStatus(32'h00000006);
        dataIs(32'h55AA55AA);
        errEn    <= 1'b0;
        stall    <= 4'h0;
        extRange <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            run(32'h00000100 | m, 32'h00000008, 32'h0BAD0BAD);
            if (m < 2) begin
                dataIs(32'hFFFFFFFF);
                waitStatus(32'h00000002);
                dataIs(crcOf(32'hFFFFFFFF, (m == 1) ? EE_B : 32'h0, (m == 1) ? EE_SZ : FLASH_SZ));
            end else begin
                waitStatus(32'h0000000A);
            end
        end
        extRange <= 1'b0;
        apb(1'b0, 8'h14, 32'h00000000);
        chkFlag("unmapped error", 1'b1, er);
        chk("unmapped data", 32'h00000000, rd);
        apb(1'b0, OFS_CTRL, 32'h00000000);
        chk("control reads zero", 32'h00000000, rd);
        end_of_test;
    end
endmodule
